// ==== tms_pkg.sv ====
// Purpose: shared constants of the two-mode serial unit data and pin block
// Assumes: 16-bit register addresses, 8-bit data
// Notes: pin index 0 clock A, 1 data A, 2 data-out, 3 clock B, 4 data B
package tms_pkg;
    localparam logic [15:0] ADDR_HOLDING = 16'hFEA3;
    localparam logic [15:0] ADDR_TUNING = 16'hFEA4;
    localparam logic [15:0] ADDR_ROUTE = 16'hFEA5;
    localparam logic [15:0] ADDR_CTRL = 16'hFEB0;
    localparam logic [15:0] ADDR_LATCH = 16'hFEB1;
    localparam logic [15:0] ADDR_DIR = 16'hFEB2;
    localparam logic [15:0] ADDR_FUNC = 16'hFEB3;
    localparam logic [15:0] ADDR_ODOPT = 16'hFEB4;

    localparam logic [7:0] HOLDING_RST = 8'h00;
    localparam logic [3:0] TUNING_RST = 4'h0;
    localparam logic [3:0] TUNING_UPPER = 4'hF;
    localparam logic [7:0] ROUTE_RST = 8'h00;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [4:0] PORT_RST = 5'h00;
    localparam logic [4:0] FUNC_RST = 5'h1F;

    // pin_route_select fields
    localparam int RT_CLK_EN = 0;
    localparam int RT_DAT_EN = 1;
    localparam int RT_SDO_EN = 2;
    localparam int RT_PAIR = 3;
    localparam int RT_CLK_OD = 4;
    localparam int RT_DAT_OD = 5;
    localparam int RT_SDO_OD = 6;

    // control register fields
    localparam int CT_PROTO = 0;
    localparam int CT_MASTER = 1;
    localparam int CT_XMIT = 2;
    localparam int CT_3WIRE = 3;
    localparam int CT_DONE = 4;

    localparam int NUM_PINS = 5;
    localparam int SYNC_STAGES = 3;
    localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_I2C_FRAME = 4'h9;
endpackage : tms_pkg

// ==== tms_pin_sync.sv ====
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module tms_pin_sync
    import tms_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic rst_val, // unused; output and stages reset high
    input wire logic pin_i, // raw pin level
    output logic pin_s // filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic out_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 1'b1;
        end else if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
        end
    end

    assign pin_s = out_reg;
endmodule : tms_pin_sync

// ==== tms_pin_drv.sv ====
// Purpose: one port pin: direction, latch, serial routing, output type
// Assumes: all controls come from the clk domain
// Notes: outputs are registered; pull-up is a request to the pad
`timescale 1ns/1ps
module tms_pin_drv
    import tms_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic dir, // 1 = output
    input wire logic latch, // port data latch
    input wire logic func_ctl, // 0 = pin given to serial unit
    input wire logic chosen, // routing picks this pin
    input wire logic enable, // serial output enable
    input wire logic od_type, // 1 = n-channel open drain
    input wire logic od_option, // user option: high level floats
    input wire logic serial, // serial signal
    output logic pin_o, // pad output level
    output logic pin_oe, // pad drive enable
    output logic pin_pu // pad pull-up on
);
    logic o_next;
    logic oe_next;
    logic pu_next;
    logic o_reg;
    logic oe_reg;
    logic pu_reg;

    always_comb begin
        o_next = 1'b0;
        oe_next = 1'b1;
        pu_next = 1'b0;
        if (!dir) begin
            // (R11) input: float or pull-up
            oe_next = 1'b0;
            pu_next = latch;
        end else if (latch) begin
            // (R13) latch high drives high, or floats when od_option is set
            o_next = 1'b1;
            oe_next = !od_option;
        end else if (!func_ctl && chosen && enable) begin
            // (R09) (R12) serial signal, OR with zero latch
            o_next = serial | latch;
            // (R07) open drain releases a high
            oe_next = od_type ? !serial : 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            o_reg <= 1'b0;
            oe_reg <= 1'b0;
            pu_reg <= 1'b0;
        end else begin
            o_reg <= o_next;
            oe_reg <= oe_next;
            pu_reg <= pu_next;
        end
    end

    assign pin_o = o_reg;
    assign pin_oe = oe_reg;
    assign pin_pu = pu_reg;
endmodule : tms_pin_drv

// ==== tms_serial_unit.sv ====
// Purpose: data buffer, shift registers and pin routing of the serial unit
// Assumes: serial clock generator and start/stop sequencer sit outside
// Notes: pins 0..4 are clock A, data A, data-out, clock B, data B
`timescale 1ns/1ps
// Operation
// (R01) I2C: store received byte at 8th fall
// (R02) serial: store received byte at 8th rise
// (R03) I2C transmitter: load shifter on start
// (R04) I2C transmitter: load on write when done
// (R05) serial: load on write when slave
// (R06) software writes zeros to tuning, bit 7
// (R07) type bit selects open drain or CMOS
// (R08) pair select routes clock and data pins
// (R09) clock/data pin drives serial OR latch
// (R10) data-out pin drives serial OR latch
// (R11) input pin floats or pulls up
// (R12) unselected or disabled output pin drives low
// (R13) latch high drives high or floats
// (R14) software clears function control before use
// (R15) data-out pin only in three-wire mode
// (R16) software sets enables and open drain
// (R17) software floats external clock, receive data
// (R18) done flag holds master clock low
// (R19) other buffer writes leave shifter alone
// (R20) buffer reads return last stored byte
module tms_serial_unit
    import tms_pkg::*;
(
    input wire logic clk, // system clock 100 MHz
    input wire logic rst_n, // async reset, low
    input wire logic [15:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [7:0] rdata, // read data, cycle after rd
    input wire logic clk_gen, // generated serial clock level
    input wire logic scl_a_i, // clock pin A level
    input wire logic sda_a_i, // data pin A level
    input wire logic scl_b_i, // clock pin B level
    input wire logic sda_b_i, // data pin B level
    output logic scl_a_o, // clock pin A output
    output logic scl_a_oe, // clock pin A drive
    output logic scl_a_pu, // clock pin A pull-up
    output logic sda_a_o, // data pin A output
    output logic sda_a_oe, // data pin A drive
    output logic sda_a_pu, // data pin A pull-up
    output logic sdo_o, // data-out pin output
    output logic sdo_oe, // data-out pin drive
    output logic sdo_pu, // data-out pin pull-up
    output logic scl_b_o, // clock pin B output
    output logic scl_b_oe, // clock pin B drive
    output logic scl_b_pu, // clock pin B pull-up
    output logic sda_b_o, // data pin B output
    output logic sda_b_oe, // data pin B drive
    output logic sda_b_pu, // data pin B pull-up
    output logic start_seen, // start condition pulse
    output logic byte_stored // received byte stored pulse
);
    logic [7:0] holding_reg;
    logic [3:0] tuning_reg;
    logic [7:0] route_reg;
    logic [4:0] ctrl_reg;
    logic [4:0] latch_reg;
    logic [4:0] dir_reg;
    logic [4:0] func_reg;
    logic [4:0] odopt_reg;
    logic [7:0] rx_reg;
    logic [7:0] tx_reg;
    logic [3:0] cnt_reg;
    logic [7:0] rdata_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    logic [3:0] raw_in;
    logic [3:0] sync_in;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic sync_mode;
    logic master;
    logic xmit;
    logic three_wire;
    logic done;
    logic wr_holding;
    logic store_rx;
    logic set_done;
    logic load_tx;
    logic scl_serial;
    logic sda_serial;
    logic [NUM_PINS-1:0] chosen_v;
    logic [NUM_PINS-1:0] enable_v;
    logic [NUM_PINS-1:0] odtype_v;
    logic [NUM_PINS-1:0] serial_v;
    logic [NUM_PINS-1:0] pin_o_v;
    logic [NUM_PINS-1:0] pin_oe_v;
    logic [NUM_PINS-1:0] pin_pu_v;

    assign sync_mode = ctrl_reg[CT_PROTO];
    assign master = ctrl_reg[CT_MASTER];
    assign xmit = ctrl_reg[CT_XMIT];
    assign three_wire = ctrl_reg[CT_3WIRE];
    assign done = ctrl_reg[CT_DONE];
    assign wr_holding = wr && (addr == ADDR_HOLDING);

    // pin inputs through three-stage synchronisers
    assign raw_in = {sda_b_i, scl_b_i, sda_a_i, scl_a_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
            tms_pin_sync u_sync (
                .clk(clk),
                .rst_n(rst_n),
                .rst_val(1'b1),
                .pin_i(raw_in[gi]),
                .pin_s(sync_in[gi])
            );
        end
    endgenerate

    // (R08) input side follows the selected pair
    assign scl_s = route_reg[RT_PAIR] ? sync_in[2] : sync_in[0];
    assign sda_s = route_reg[RT_PAIR] ? sync_in[3] : sync_in[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_prev_reg;
    assign scl_fall = !scl_s && scl_prev_reg;
    assign start_det = !sync_mode && scl_s && scl_prev_reg && sda_prev_reg && !sda_s;

    // bit counter: clock rises in current frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 4'h0;
        end else if (start_det) begin
            cnt_reg <= 4'h0;
        end else if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
        end else if (scl_fall && sync_mode && cnt_reg == BIT_COUNT_BYTE) begin
            cnt_reg <= 4'h0;
        end else if (scl_fall && !sync_mode && cnt_reg == BIT_COUNT_I2C_FRAME) begin
            cnt_reg <= 4'h0;
        end
    end

    // receive shifter samples data on clock rise, data bits only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_reg <= 8'h00;
        end else if (scl_rise && cnt_reg < BIT_COUNT_BYTE) begin
            rx_reg <= {rx_reg[6:0], sda_s};
        end
    end

    always_comb begin
        store_rx = 1'b0;
        if (!sync_mode) begin
            // (R01) falling edge of 8th clock
            store_rx = scl_fall && cnt_reg == BIT_COUNT_BYTE;
        end else begin
            // (R02) rising edge of 8th clock
            store_rx = scl_rise && cnt_reg == BIT_COUNT_BYTE - 4'h1;
        end
    end

    // done after ack clock in I2C, after 8th rise in serial mode
    assign set_done = sync_mode ? store_rx : (scl_fall && cnt_reg == BIT_COUNT_I2C_FRAME);

    always_comb begin
        load_tx = 1'b0;
        if (!sync_mode && xmit) begin
            // (R03) (R04) start seen or write while done
            load_tx = start_det || (wr_holding && done);
        end else if (sync_mode && xmit) begin
            // (R05) write while slave
            load_tx = wr_holding && !master;
        end
    end

    // (R20) holding register: received byte wins a same-cycle write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            holding_reg <= HOLDING_RST;
        end else if (store_rx) begin
            holding_reg <= sync_mode ? {rx_reg[6:0], sda_s} : rx_reg;
        end else if (wr_holding) begin
            holding_reg <= wdata;
        end
    end

    // (R19) shifter changes only on load or clock fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_reg <= 8'hFF;
        end else if (load_tx) begin
            // a qualifying write sends the new byte, not the old one
            tx_reg <= wr_holding ? wdata : holding_reg;
        end else if (scl_fall && cnt_reg != 4'h0 && cnt_reg < BIT_COUNT_BYTE) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
        end else if (scl_fall && cnt_reg == BIT_COUNT_BYTE) begin
            tx_reg <= 8'hFF;
        end
    end

    // control register; done set wins over a software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            if (wr && addr == ADDR_CTRL) begin
                ctrl_reg <= wdata[4:0];
            end
            if (set_done) begin
                ctrl_reg[CT_DONE] <= 1'b1;
            end
        end
    end

    // (R06) tuning bits 3..0 and route bit 7 stored as written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tuning_reg <= TUNING_RST;
            route_reg <= ROUTE_RST;
        end else if (wr && addr == ADDR_TUNING) begin
            tuning_reg <= wdata[3:0];
        end else if (wr && addr == ADDR_ROUTE) begin
            route_reg <= wdata;
        end
    end

    // (R14) port registers: latch, direction, function, option
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_reg <= PORT_RST;
            dir_reg <= PORT_RST;
            func_reg <= FUNC_RST;
            odopt_reg <= PORT_RST;
        end else if (wr) begin
            case (addr)
                ADDR_LATCH: latch_reg <= wdata[4:0];
                ADDR_DIR: dir_reg <= wdata[4:0];
                ADDR_FUNC: func_reg <= wdata[4:0];
                ADDR_ODOPT: odopt_reg <= wdata[4:0];
                default: ;
            endcase
        end
    end

    // read data, valid the cycle after rd
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (rd) begin
            case (addr)
                ADDR_HOLDING: rdata_reg <= holding_reg;
                ADDR_TUNING: rdata_reg <= {TUNING_UPPER, tuning_reg};
                ADDR_ROUTE: rdata_reg <= route_reg;
                ADDR_CTRL: rdata_reg <= {3'h0, ctrl_reg};
                ADDR_LATCH: rdata_reg <= {3'h0, latch_reg};
                ADDR_DIR: rdata_reg <= {3'h0, dir_reg};
                ADDR_FUNC: rdata_reg <= {3'h0, func_reg};
                ADDR_ODOPT: rdata_reg <= {3'h0, odopt_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign rdata = rdata_reg;

    // (R18) master clock held low while done
    assign scl_serial = master ? (clk_gen && !done) : 1'b1;
    // three-wire serial mode releases data line
    assign sda_serial = (three_wire && sync_mode) ? 1'b1 : tx_reg[7];

    always_comb begin
        // (R08) pair select picks A or B pins
        chosen_v[0] = !route_reg[RT_PAIR];
        chosen_v[1] = !route_reg[RT_PAIR];
        // (R15) data-out pin only in three-wire mode
        chosen_v[2] = sync_mode && three_wire;
        chosen_v[3] = route_reg[RT_PAIR];
        chosen_v[4] = route_reg[RT_PAIR];
        enable_v = {route_reg[RT_DAT_EN], route_reg[RT_CLK_EN], route_reg[RT_SDO_EN],
                    route_reg[RT_DAT_EN], route_reg[RT_CLK_EN]};
        odtype_v = {route_reg[RT_DAT_OD], route_reg[RT_CLK_OD], route_reg[RT_SDO_OD],
                    route_reg[RT_DAT_OD], route_reg[RT_CLK_OD]};
        // (R10) data-out pin carries transmit data
        serial_v = {sda_serial, scl_serial, tx_reg[7], sda_serial, scl_serial};
    end

    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            tms_pin_drv u_pin (
                .clk(clk),
                .rst_n(rst_n),
                .dir(dir_reg[gi]),
                .latch(latch_reg[gi]),
                .func_ctl(func_reg[gi]),
                .chosen(chosen_v[gi]),
                .enable(enable_v[gi]),
                .od_type(odtype_v[gi]),
                .od_option(odopt_reg[gi]),
                .serial(serial_v[gi]),
                .pin_o(pin_o_v[gi]),
                .pin_oe(pin_oe_v[gi]),
                .pin_pu(pin_pu_v[gi])
            );
        end
    endgenerate

    assign scl_a_o = pin_o_v[0];
    assign scl_a_oe = pin_oe_v[0];
    assign scl_a_pu = pin_pu_v[0];
    assign sda_a_o = pin_o_v[1];
    assign sda_a_oe = pin_oe_v[1];
    assign sda_a_pu = pin_pu_v[1];
    assign sdo_o = pin_o_v[2];
    assign sdo_oe = pin_oe_v[2];
    assign sdo_pu = pin_pu_v[2];
    assign scl_b_o = pin_o_v[3];
    assign scl_b_oe = pin_oe_v[3];
    assign scl_b_pu = pin_pu_v[3];
    assign sda_b_o = pin_o_v[4];
    assign sda_b_oe = pin_oe_v[4];
    assign sda_b_pu = pin_pu_v[4];
    assign start_seen = start_det;
    assign byte_stored = store_rx;
endmodule : tms_serial_unit

// ==== tms_chk.sv ====
// Purpose: port-level checks of the two-mode serial unit
// Assumes: pin controls mirrored from bus writes
// Notes: pin checks only once function control is cleared
`timescale 1ns/1ps
module tms_chk
    import tms_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_n, // async reset, low
    input wire logic [15:0] addr, // register address
    input wire logic [7:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [7:0] rdata, // read data
    input wire logic scl_a_o, // clock A level
    input wire logic scl_a_oe, // clock A drive
    input wire logic scl_a_pu, // clock A pull-up
    input wire logic sda_a_oe, // data A drive
    input wire logic sda_a_pu, // data A pull-up
    input wire logic sda_b_o, // data B level
    input wire logic sda_b_oe, // data B drive
    input wire logic byte_stored // store pulse
);
    logic [7:0] rt_m, lat_m, dir_m, fn_m, od_m;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rt_m <= 8'h00;
            lat_m <= 8'h00;
            dir_m <= 8'h00;
            fn_m <= 8'h1F;
            od_m <= 8'h00;
        end else if (wr) begin
            case (addr)
                ADDR_ROUTE: rt_m <= wdata;
                ADDR_LATCH: lat_m <= wdata;
                ADDR_DIR: dir_m <= wdata;
                ADDR_FUNC: fn_m <= wdata;
                ADDR_ODOPT: od_m <= wdata;
                default: ;
            endcase
        end
    end

    // setting held long enough for the registered pin
    sequence held(c);
        c [*2];
    endsequence

    chk_float_idle: assert property (held(!dir_m[0] && !lat_m[0] && !fn_m[0]) |-> !scl_a_oe && !scl_a_pu)
        else $error("clock pin A not floating");
    chk_pullup_on: assert property (held(!dir_m[1] && lat_m[1] && !fn_m[1]) |-> sda_a_pu && !sda_a_oe)
        else $error("data pin A pull-up missing");
    chk_latch_high: assert property (held(dir_m[4] && lat_m[4] && !od_m[4] && !fn_m[4]) |-> sda_b_oe && sda_b_o)
        else $error("data pin B not driven high");
    chk_latch_open: assert property (held(dir_m[4] && lat_m[4] && od_m[4] && !fn_m[4]) |-> !sda_b_oe)
        else $error("data pin B drives with open option");
    chk_pair_low: assert property (held(dir_m[0] && !lat_m[0] && !fn_m[0] && rt_m[RT_PAIR])
        |-> scl_a_oe && !scl_a_o)
        else $error("unselected clock pin A not low");
    chk_enable_low: assert property (held(dir_m[0] && !lat_m[0] && !fn_m[0] && !rt_m[RT_CLK_EN])
        |-> scl_a_oe && !scl_a_o)
        else $error("disabled clock pin A not low");
    chk_cmos_drive: assert property (held(dir_m[0] && !lat_m[0] && !fn_m[0] && rt_m[RT_CLK_EN]
        && !rt_m[RT_PAIR] && !rt_m[RT_CLK_OD]) |-> scl_a_oe)
        else $error("push-pull clock pin A released");
    chk_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_store_pulse: assert property (byte_stored |=> !byte_stored)
        else $error("store pulse longer than one cycle");
endmodule : tms_chk

bind tms_serial_unit tms_chk u_chk (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .scl_a_o, .scl_a_oe,
    .scl_a_pu, .sda_a_oe, .sda_a_pu, .sda_b_o, .sda_b_oe, .byte_stored);

// ==== tms_peer.sv ====
// Purpose: bus peer that clocks frames and drives data
// Assumes: open-drain lines with pull-ups, 125 ns bit period
// Notes: clock stands still between frames
`timescale 1ns/1ps
module tms_peer (
    input wire logic d_in, // data line seen by the peer
    output logic scl_p, // clock, low pulls the line
    output logic sda_p // data, low pulls the line
);
    initial begin
        scl_p = 1'b1;
        sda_p = 1'b1;
    end

    task automatic start_c(input logic own_clk);
        scl_p = 1'b1;
        #62.5 sda_p = 1'b0;
        #62.5 if (own_clk) scl_p = 1'b0;
        #62.5 sda_p = 1'b1;
    endtask : start_c

    // msb first, data changes only while clock low
    task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
        rx = 9'h000;
        for (int i = 0; i < n; i++) begin
            sda_p = tx[8 - i];
            #62.5 scl_p = 1'b1;
            rx = {rx[7:0], d_in};
            #62.5 scl_p = 1'b0;
        end
        sda_p = 1'b1;
    endtask : xfer
endmodule : tms_peer

// ==== testbench.sv ====
// Purpose: self-checking bench of the two-mode serial unit
// Assumes: peer model on pin pair A and data-out
// Notes: lines resolved as wired-and with pull-ups
`timescale 1ns/1ps
module testbench;
    import tms_pkg::*;
    logic clk, rst_n, wr, rd, clk_gen, sel_sdo, st_scl;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [8:0] rx;
    logic scl_a_o, scl_a_oe, scl_a_pu, sda_a_o, sda_a_oe, sda_a_pu, sdo_o, sdo_oe, sdo_pu;
    logic scl_b_o, scl_b_oe, scl_b_pu, sda_b_o, sda_b_oe, sda_b_pu, start_seen, byte_stored;
    logic scl_p, sda_p;
    int miscompares = 0;
    int n_tests = 0;
    int n_st = 0;
    int n_sp = 0;
    wire scl_ln = (scl_a_oe ? scl_a_o : 1'b1) & scl_p;
    wire sda_ln = (sda_a_oe ? sda_a_o : 1'b1) & sda_p;
    wire sdo_ln = sdo_oe ? sdo_o : 1'b1;
    wire scl_bl = scl_b_oe ? scl_b_o : 1'b1;
    wire sda_bl = sda_b_oe ? sda_b_o : 1'b1;

    tms_serial_unit DUT (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .clk_gen, .scl_a_i(scl_ln),
        .sda_a_i(sda_ln), .scl_b_i(scl_bl), .sda_b_i(sda_bl), .scl_a_o, .scl_a_oe, .scl_a_pu, .sda_a_o,
        .sda_a_oe, .sda_a_pu, .sdo_o, .sdo_oe, .sdo_pu, .scl_b_o, .scl_b_oe, .scl_b_pu, .sda_b_o,
        .sda_b_oe, .sda_b_pu, .start_seen, .byte_stored);
    tms_peer peer (.d_in(sel_sdo ? sdo_ln : sda_ln), .scl_p, .sda_p);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (start_seen === 1'b1) n_sp <= n_sp + 1;
        if (byte_stored === 1'b1) begin
            n_st <= n_st + 1;
            st_scl <= scl_ln;
        end
    end

    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wr_r(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_r

    task automatic rchk(input string nm, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm, {1'b0, rdata}, {1'b0, exp});
    endtask : rchk

    task automatic cfg(input logic [7:0] c, rt, di, la, od);
        wr_r(ADDR_FUNC, 8'h00);
        wr_r(ADDR_CTRL, c);
        wr_r(ADDR_ROUTE, rt);
        wr_r(ADDR_DIR, di);
        wr_r(ADDR_LATCH, la);
        wr_r(ADDR_ODOPT, od);
    endtask : cfg

    task automatic re_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
    endtask : re_reset

    task automatic t_regs();
        rchk("holding", ADDR_HOLDING, HOLDING_RST);
        rchk("tuning", ADDR_TUNING, {TUNING_UPPER, TUNING_RST});
        rchk("route", ADDR_ROUTE, ROUTE_RST);
        rchk("unmapped", 16'hFEA6, 8'h00);
        wr_r(ADDR_HOLDING, 8'h96);
        rchk("holding", ADDR_HOLDING, 8'h96);
        // zeros to tuning and route bit 7
        wr_r(ADDR_TUNING, 8'h00);
        wr_r(ADDR_ROUTE, 8'h7F);
        rchk("tuning", ADDR_TUNING, 8'hF0);
        rchk("route", ADDR_ROUTE, 8'h7F);
    endtask : t_regs

    task automatic t_pins();
        logic [36:0] tbl [8] = '{{8'h00, 8'h1F, 8'h00, 8'h00, 5'b01001}, {8'h01, 8'h1F, 8'h00, 8'h00, 5'b11001},
            {8'h09, 8'h1F, 8'h00, 8'h00, 5'b01011}, {8'h11, 8'h1F, 8'h00, 8'h00, 5'b00001},
            {8'h11, 8'h1F, 8'h1F, 8'h00, 5'b11011}, {8'h11, 8'h1F, 8'h1F, 8'h1F, 5'b00000},
            {8'h00, 8'h00, 8'h1F, 8'h00, 5'b00100}, {8'h00, 8'h00, 8'h00, 8'h00, 5'b00000}};
        foreach (tbl[i]) begin
            cfg(8'h00, tbl[i][36:29], tbl[i][28:21], tbl[i][20:13], tbl[i][12:5]);
            cyc(3);
            chk("pins", {4'h0, scl_a_o & scl_a_oe, scl_a_oe, scl_a_pu, scl_b_o & scl_b_oe, scl_b_oe},
                {4'h0, tbl[i][4:0]});
        end
    endtask : t_pins

    task automatic t_i2c_rx();
        int n0;
        re_reset();
        // enables and open drain for the bus
        cfg(8'h00, 8'h33, 8'h1F, 8'h00, 8'h00);
        n0 = n_st;
        peer.start_c(1'b1);
        peer.xfer({8'hA5, 1'b1}, 9, rx);
        cyc(8);
        chk("stores", 9'(n_st - n0), 9'h001);
        chk("store clock", {8'h00, st_scl}, 9'h000);
        chk("starts", 9'(n_sp), 9'h001);
        rchk("holding", ADDR_HOLDING, 8'hA5);
    endtask : t_i2c_rx

    task automatic t_i2c_tx();
        re_reset();
        cfg(8'h04, 8'h33, 8'h1F, 8'h00, 8'h00);
        wr_r(ADDR_HOLDING, 8'h3C);
        cyc(3);
        chk("idle data", {8'h00, sda_ln}, 9'h001);
        peer.start_c(1'b1);
        chk("first bit", {8'h00, sda_ln}, 9'h000);
        peer.xfer(9'h1FF, 9, rx);
        cyc(8);
        chk("sent byte", rx, {8'h3C, 1'b1});
        rchk("holding", ADDR_HOLDING, 8'h3C);
        wr_r(ADDR_HOLDING, 8'hA5);
        cyc(3);
        chk("reload", {8'h00, sda_ln}, 9'h001);
    endtask : t_i2c_tx

    task automatic t_ser();
        int n0;
        re_reset();
        // external clock pin floats, receive data open drain
        cfg(8'h0D, 8'h27, 8'h1E, 8'h00, 8'h00);
        sel_sdo = 1'b1;
        wr_r(ADDR_HOLDING, 8'h4B);
        cyc(3);
        chk("data-out first", {8'h00, sdo_ln}, 9'h000);
        n0 = n_st;
        peer.xfer({8'h96, 1'b1}, 8, rx);
        cyc(8);
        chk("data-out byte", rx, {1'b0, 8'h4B});
        chk("stores", 9'(n_st - n0), 9'h001);
        chk("store clock", {8'h00, st_scl}, 9'h001);
        rchk("holding", ADDR_HOLDING, 8'h96);
        sel_sdo = 1'b0;
    endtask : t_ser

    task automatic t_master();
        logic hi;
        hi = 1'b0;
        re_reset();
        cfg(8'h06, 8'h33, 8'h1F, 8'h00, 8'h00);
        wr_r(ADDR_HOLDING, 8'hFF);
        peer.start_c(1'b0);
        for (int i = 0; i < 13; i++) begin
            clk_gen <= 1'b0;
            cyc(6);
            clk_gen <= 1'b1;
            cyc(6);
            if (i > 9) hi = hi | scl_ln;
        end
        chk("clock held", {8'h00, hi}, 9'h000);
        wr_r(ADDR_CTRL, 8'h06);
        cyc(3);
        chk("clock freed", {8'h00, scl_ln}, 9'h001);
    endtask : t_master

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        clk_gen = 1'b1;
        sel_sdo = 1'b0;
        cyc(8);
        rst_n <= 1'b1;
        t_regs();
        t_pins();
        t_i2c_rx();
        t_i2c_tx();
        t_ser();
        t_master();
        finish_test();
    end

    initial begin
        #300000;
        miscompares++;
        finish_test();
    end
endmodule : testbench
